// ### core/rsoca_pkg.sv
/*
  Constants and shared types for the regenerator-section overhead channel adapter.
  Assumes one 40 MHz system clock, with every input sampled on it as a strobe or a level.
*/
package rsoca_pkg;

  // ****************************************
  // frame geometry
  // ****************************************
  localparam logic [11:0] RSOCA_FRAME_BYTES = 12'd2430;
  localparam logic [11:0] RSOCA_LAST_IDX = 12'd2429;
  localparam logic [11:0] RSOCA_IDX_E1 = 12'd273;
  localparam logic [11:0] RSOCA_IDX_F1 = 12'd276;
  localparam logic [11:0] RSOCA_IDX_D1 = 12'd540;
  localparam logic [11:0] RSOCA_IDX_D2 = 12'd543;
  localparam logic [11:0] RSOCA_IDX_D3 = 12'd546;
  localparam logic [11:0] RSOCA_IDX_USER_REQ = 12'h000;

  // ****************************************
  // timing
  // ****************************************
  localparam int RSOCA_CLK_HZ = 40000000;
  localparam int RSOCA_OW_RATE_HZ = 64000;
  localparam int RSOCA_OW_DIV_INT = RSOCA_CLK_HZ / RSOCA_OW_RATE_HZ;
  localparam logic [9:0] RSOCA_OW_DIV_LAST = 10'(RSOCA_OW_DIV_INT - 1);
  localparam int RSOCA_WANDER_NS = 18000;
  localparam int RSOCA_OCTET_NS = 8 * (1000000000 / RSOCA_OW_RATE_HZ);

  // ****************************************
  // slip store
  // ****************************************
  // one octet covers 125 us, far above the wander figure; depth 8 leaves margin
  localparam int RSOCA_SLIP_DEPTH = 8;
  localparam int RSOCA_SLIP_WIDTH = 8;
  localparam logic [3:0] RSOCA_SLIP_LOW = 4'h0;
  localparam logic [3:0] RSOCA_SLIP_HIGH = 4'h7;

  // ****************************************
  // values
  // ****************************************
  localparam logic [7:0] RSOCA_ALL_ONES = 8'hFF;
  localparam logic [7:0] RSOCA_BYTE_RST = 8'h00;
  localparam logic [2:0] RSOCA_LAST_BIT = 3'h7;
  localparam logic [3:0] RSOCA_OCTET_BITS = 4'h8;

  typedef enum logic {RSOCA_SEL_E1, RSOCA_SEL_F1} rsoca_sel_t;

endpackage

// ### core/rsoca_fifo.sv
/*
  Parameterised first-word-fall-through FIFO with valid/ready on both sides.
  Assumes a single clock and an already synchronised reset.
*/
`timescale 1ns/1ps
module rsoca_fifo
  import rsoca_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [$clog2(DEPTH):0] level
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } rsoca_fifo_st_t;

  rsoca_fifo_st_t st_q;
  rsoca_fifo_st_t st_d;
  logic push;
  logic pop;

  assign in_ready = (st_q.cnt != (AW+1)'(DEPTH));
  assign out_valid = (st_q.cnt != '0);
  assign out_data = st_q.mem[st_q.rd];
  assign level = st_q.cnt;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // pointer and count update; full blocks writes, empty blocks reads
  always_comb begin
    st_d = st_q;
    if (push) begin
      st_d.mem[st_q.wr] = in_data;
      st_d.wr = (st_q.wr == AW'(DEPTH-1)) ? '0 : st_q.wr + AW'(1);
    end
    if (pop) begin
      st_d.rd = (st_q.rd == AW'(DEPTH-1)) ? '0 : st_q.rd + AW'(1);
    end
    st_d.cnt = st_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

endmodule

// ### core/rsoca_top.sv
/*
  Regenerator-section overhead channel adapter: comm channel sink, orderwire
  source and sink on E1 or F1, user channel sink on F1, and user channel source on F1 while the orderwire source is on E1.
  Assumes all inputs are synchronous to clk; byte clocks arrive as one-cycle
  strobes, and the frame-start strobe marks byte 0 of a frame.
*/
`timescale 1ns/1ps
module rsoca_top
  import rsoca_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] section_overhead_data_in,
  input wire logic section_byte_clock,
  input wire logic section_frame_start,
  input wire logic section_trail_fail_in,
  input wire logic line_timing_clock,
  input wire logic line_timing_frame_start,
  output logic [7:0] section_overhead_data_out,
  output logic section_overhead_insert,
  output logic [7:0] comm_channel_data,
  output logic comm_channel_clock,
  output logic comm_channel_server_fail,
  input wire rsoca_sel_t ow_src_sel,
  input wire rsoca_sel_t ow_sink_sel,
  input wire logic orderwire_src_data,
  input wire logic orderwire_src_clock,
  input wire logic orderwire_src_octet_start,
  output logic orderwire_src_ready,
  output logic orderwire_data,
  output logic orderwire_clock,
  output logic orderwire_octet_start,
  output logic orderwire_server_fail,
  output logic user_src_clock,
  input wire logic [7:0] user_src_data,
  output logic [7:0] user_channel_data,
  output logic user_channel_clock,
  output logic user_channel_server_fail
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [11:0] scnt;
    logic [11:0] lcnt;
    logic [7:0] sec_out;
    logic sec_ins;
    logic [7:0] dcc_data;
    logic dcc_clk;
    logic dcc_fail;
    logic [7:0] in_sh;
    logic [3:0] in_n;
    logic [7:0] push_data;
    logic push;
    logic [7:0] last;
    logic drop;
    logic src_rdy;
    logic [7:0] store;
    logic [9:0] div;
    logic [2:0] bitn;
    logic [7:0] sh;
    logic ow_d;
    logic ow_clk;
    logic ow_os;
    logic ow_fail;
    logic user_req;
    logic user_cap;
    logic [7:0] user_byte;
    logic [7:0] usr_data;
    logic usr_clk;
    logic usr_fail;
  } rsoca_top_st_t;

  rsoca_top_st_t st_q;
  rsoca_top_st_t st_d;
  logic [1:0] rst_sync_q;
  logic rst_q;
  logic [11:0] s_idx;
  logic [11:0] l_idx;
  logic [11:0] ow_src_idx;
  logic [11:0] ow_sink_idx;
  logic dcc_hit;
  logic ow_snk_hit;
  logic usr_snk_hit;
  logic ow_src_hit;
  logic usr_src_hit;
  logic [7:0] fifo_out;
  logic fifo_valid;
  logic fifo_in_ready;
  logic fifo_pop;
  logic [3:0] fifo_level;

  // ****************************************
  // reset release
  // ****************************************
  // two stages so that release never lands near an edge of the logic
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_q = rst_sync_q[1];

  // ****************************************
  // frame position
  // ****************************************
  // index of the byte that is present in this cycle on each side
  assign s_idx = section_frame_start ? 12'h000 :
                 (st_q.scnt == RSOCA_LAST_IDX) ? 12'h000 : st_q.scnt + 12'h001;
  assign l_idx = line_timing_frame_start ? 12'h000 :
                 (st_q.lcnt == RSOCA_LAST_IDX) ? 12'h000 : st_q.lcnt + 12'h001;
  assign ow_src_idx = (ow_src_sel == RSOCA_SEL_F1) ? RSOCA_IDX_F1 : RSOCA_IDX_E1;
  assign ow_sink_idx = (ow_sink_sel == RSOCA_SEL_F1) ? RSOCA_IDX_F1 : RSOCA_IDX_E1;
  assign dcc_hit = section_byte_clock && (s_idx == RSOCA_IDX_D1 || s_idx == RSOCA_IDX_D2 ||
                   s_idx == RSOCA_IDX_D3);
  assign ow_snk_hit = section_byte_clock && (s_idx == ow_sink_idx);
  assign usr_snk_hit = section_byte_clock && (s_idx == RSOCA_IDX_F1);
  assign ow_src_hit = line_timing_clock && (l_idx == ow_src_idx);
  // orderwire wins F1 when it is routed there; the user channel then stays off air
  assign usr_src_hit = line_timing_clock && (l_idx == RSOCA_IDX_F1) &&
                       (ow_src_sel != RSOCA_SEL_F1);
  // a pop at the slot when above the low mark, and the extra pop of a drop
  assign fifo_pop = (ow_src_hit && fifo_level > RSOCA_SLIP_LOW) || st_q.drop;

  // ****************************************
  // slip store
  // ****************************************
  rsoca_fifo #(
    .WIDTH(RSOCA_SLIP_WIDTH),
    .DEPTH(RSOCA_SLIP_DEPTH)
  ) u_slip (
    .clk(clk),
    .rst_n(rst_q),
    .in_data(st_q.push_data),
    .in_valid(st_q.push),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .level(fifo_level)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    st_d = st_q;
    if (section_byte_clock) begin
      st_d.scnt = s_idx;
    end
    if (line_timing_clock) begin
      st_d.lcnt = l_idx;
    end
    // comm channel sink: byte-wide delivery with a one-cycle clock pulse
    st_d.dcc_clk = dcc_hit;
    if (dcc_hit) begin
      st_d.dcc_data = section_overhead_data_in;
    end
    st_d.dcc_fail = section_trail_fail_in;
    // orderwire source: assemble octets msb first on the channel clock
    st_d.push = 1'b0;
    st_d.src_rdy = fifo_in_ready;
    if (orderwire_src_clock) begin
      if (orderwire_src_octet_start) begin
        st_d.in_sh = {7'h00, orderwire_src_data};
        st_d.in_n = 4'h1;
      end else begin
        st_d.in_sh = {st_q.in_sh[6:0], orderwire_src_data};
        st_d.in_n = st_q.in_n + 4'h1;
      end
      if (st_d.in_n == RSOCA_OCTET_BITS) begin
        st_d.push = 1'b1;
        st_d.push_data = st_d.in_sh;
        st_d.in_n = 4'h0;
      end
    end
    // overhead insertion toward the section, one octet per frame per channel
    st_d.sec_ins = ow_src_hit || usr_src_hit;
    st_d.sec_out = RSOCA_BYTE_RST;
    st_d.drop = 1'b0;
    if (ow_src_hit) begin
      if (fifo_level <= RSOCA_SLIP_LOW) begin
        // store ran dry: the read is cancelled and the held octet goes again
        st_d.sec_out = st_q.last;
      end else begin
        st_d.sec_out = fifo_out;
        st_d.last = fifo_out;
        st_d.drop = (fifo_level >= RSOCA_SLIP_HIGH);
      end
    end else if (usr_src_hit) begin
      st_d.sec_out = st_q.user_byte;
    end
    // user source asks its client for an octet once per frame
    st_d.user_req = line_timing_clock && (l_idx == RSOCA_IDX_USER_REQ);
    st_d.user_cap = st_q.user_req;
    if (st_q.user_cap) begin
      st_d.user_byte = user_src_data;
    end
    // orderwire sink: latch the selected byte, smooth it out at 64 kbit/s
    if (ow_snk_hit) begin
      st_d.store = section_overhead_data_in;
    end
    st_d.ow_fail = section_trail_fail_in;
    st_d.ow_clk = 1'b0;
    st_d.ow_os = 1'b0;
    if (st_q.div == RSOCA_OW_DIV_LAST) begin
      st_d.div = 10'h000;
      st_d.ow_clk = 1'b1;
      st_d.ow_os = (st_q.bitn == 3'h0);
      if (st_q.bitn == 3'h0) begin
        st_d.sh = {st_q.store[6:0], 1'b0};
        st_d.ow_d = section_trail_fail_in | st_q.store[7];
      end else begin
        st_d.sh = {st_q.sh[6:0], 1'b0};
        st_d.ow_d = section_trail_fail_in | st_q.sh[7];
      end
      st_d.bitn = (st_q.bitn == RSOCA_LAST_BIT) ? 3'h0 : st_q.bitn + 3'h1;
    end else begin
      st_d.div = st_q.div + 10'h001;
    end
    // user channel sink
    st_d.usr_clk = usr_snk_hit;
    if (usr_snk_hit) begin
      st_d.usr_data = section_trail_fail_in ? RSOCA_ALL_ONES :
                      section_overhead_data_in;
    end
    st_d.usr_fail = section_trail_fail_in;
  end

  always_ff @(posedge clk or negedge rst_q) begin
    if (!rst_q) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign section_overhead_data_out = st_q.sec_out;
  assign section_overhead_insert = st_q.sec_ins;
  assign comm_channel_data = st_q.dcc_data;
  assign comm_channel_clock = st_q.dcc_clk;
  assign comm_channel_server_fail = st_q.dcc_fail;
  assign orderwire_src_ready = st_q.src_rdy;
  assign orderwire_data = st_q.ow_d;
  assign orderwire_clock = st_q.ow_clk;
  assign orderwire_octet_start = st_q.ow_os;
  assign orderwire_server_fail = st_q.ow_fail;
  assign user_src_clock = st_q.user_req;
  assign user_channel_data = st_q.usr_data;
  assign user_channel_clock = st_q.usr_clk;
  assign user_channel_server_fail = st_q.usr_fail;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_q);

  chk_dcc_fail_follow: assert property (
    section_trail_fail_in |=> comm_channel_server_fail)
    else $error("comm channel server fail did not follow trail fail");
  chk_dcc_slot_only: assert property (
    comm_channel_clock |-> $past(dcc_hit))
    else $error("comm channel clock outside D1-D3");
  chk_ow_insert_slot: assert property (
    ow_src_hit |=> section_overhead_insert)
    else $error("orderwire slot not inserted");
  chk_ow_slip_repeat: assert property (
    ow_src_hit && fifo_level == 4'h0 |=> section_overhead_data_out == $past(st_q.last))
    else $error("cancelled read did not resend held octet");
  chk_ow_drop_pop: assert property (
    ow_src_hit && fifo_level >= RSOCA_SLIP_HIGH |=> fifo_pop)
    else $error("near-full store did not drop an octet");
  chk_ow_sink_latch: assert property (
    ow_snk_hit |=> st_q.store == $past(section_overhead_data_in))
    else $error("orderwire store missed the selected byte");
  chk_ow_tick_gap: assert property (
    orderwire_clock |=> !orderwire_clock [*8])
    else $error("orderwire clock too fast");
  chk_ow_ais_ones: assert property (
    orderwire_clock && $past(section_trail_fail_in) |-> orderwire_data)
    else $error("orderwire sink not all ones under trail fail");
  chk_usr_ais_ones: assert property (
    user_channel_clock && $past(section_trail_fail_in) |-> user_channel_data == 8'hFF)
    else $error("user sink not all ones under trail fail");
  // the user slot must carry the octet captured from the client, nothing older
  chk_usr_insert_slot: assert property (
    usr_src_hit |=> section_overhead_insert && section_overhead_data_out == $past(st_q.user_byte))
    else $error("user channel octet not inserted in its slot");
  chk_usr_req_frame: assert property (
    user_src_clock |-> $past(line_timing_clock && l_idx == RSOCA_IDX_USER_REQ))
    else $error("user client clock outside frame start");

  cov_slip_cancel: cover property (ow_src_hit && fifo_level == 4'h0);
  cov_slip_drop: cover property (ow_src_hit && fifo_level >= RSOCA_SLIP_HIGH);
  cov_dcc_byte: cover property (comm_channel_clock && !comm_channel_server_fail);
  cov_usr_ais: cover property (user_channel_clock && user_channel_server_fail);

endmodule

// ### dv/rsoca_rs_model.sv
/*
  Section-side partner: sends byte strobes, frame starts and overhead bytes.
  Assumes the bench drives run and slow; the same timing feeds both directions.
*/
`timescale 1ns/1ps
module rsoca_rs_model
  import rsoca_pkg::*;
(
  input wire logic clk,
  input wire logic run,
  input wire logic slow,
  output logic strobe,
  output logic fs,
  output logic [7:0] data
);
  logic [11:0] idx;
  logic [7:0] fcnt;
  logic ph;
  initial begin
    strobe = 1'b0;
    fs = 1'b0;
    data = 8'h00;
    idx = RSOCA_LAST_IDX;
    fcnt = 8'h00;
    ph = 1'b0;
  end
  // byte every cycle, or every other cycle when slow; bytes change each frame
  always @(negedge clk) begin
    ph = slow ? ~ph : 1'b1;
    strobe = run && ph;
    fs = 1'b0;
    if (strobe) begin
      idx = (idx == RSOCA_LAST_IDX) ? 12'h000 : idx + 12'h001;
      fcnt = fcnt + {7'h00, idx == 12'h000};
      fs = (idx == 12'h000);
      data = idx[7:0] + {fcnt[4:0], 3'h5};
    end else begin
      data = ~data; // stale bytes must never look valid
    end
  end
endmodule

// ### dv/stm1_rs_overhead_channel_adapt_tb_top.sv
/*
  Self-checking bench for the overhead channel adapter.
  Assumes the section model drives receive and transmit timing alike.
*/
`timescale 1ns/1ps
module stm1_rs_overhead_channel_adapt_tb_top
  import rsoca_pkg::*;
();
  logic clk = 1'b0;
  logic rst_n, tf, tf_q, run, slow, owd, owc, ows, strobe, fs;
  logic [7:0] sdata, udat, last, asm, a_cur, a_prev, st_cur, st_prev;
  logic [1:0] cfg_s, cfg_p;
  rsoca_sel_t src_sel, snk_sel;
  int n_mismatch, checked, n_rep, n_skip, n_acc, bidx, lslot, gap, nb, nst;
  integer seed = 96;
  logic [7:0] qc[$], qu[$], qo[$];
  logic [7:0] section_overhead_data_out, comm_channel_data, user_channel_data;
  logic section_overhead_insert, comm_channel_clock, comm_channel_server_fail;
  logic orderwire_src_ready, orderwire_data, orderwire_clock, orderwire_octet_start;
  logic orderwire_server_fail, user_src_clock, user_channel_clock, user_channel_server_fail;

  always #12.5 clk = ~clk;

  rsoca_rs_model far_end (.clk, .run, .slow, .strobe, .fs, .data(sdata));
  rsoca_top uut (
    .clk, .rst_n, .section_overhead_data_in(sdata), .section_byte_clock(strobe),
    .section_frame_start(fs), .section_trail_fail_in(tf), .line_timing_clock(strobe),
    .line_timing_frame_start(fs), .section_overhead_data_out, .section_overhead_insert,
    .comm_channel_data, .comm_channel_clock, .comm_channel_server_fail,
    .ow_src_sel(src_sel), .ow_sink_sel(snk_sel), .orderwire_src_data(owd),
    .orderwire_src_clock(owc), .orderwire_src_octet_start(ows), .orderwire_src_ready,
    .orderwire_data, .orderwire_clock, .orderwire_octet_start, .orderwire_server_fail,
    .user_src_clock, .user_src_data(udat), .user_channel_data, .user_channel_clock,
    .user_channel_server_fail
  );

  // ****************************************
  // compare and report
  // ****************************************
  task automatic test_done();
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp1(input logic got);
    cmp8({7'h00, got}, 8'h01);
  endtask
  function automatic int slot(input rsoca_sel_t s);
    return (s == RSOCA_SEL_E1) ? int'(RSOCA_IDX_E1) : int'(RSOCA_IDX_F1);
  endfunction

  // ****************************************
  // drivers
  // ****************************************
  // serial octet, msb first, one bit strobe every other cycle
  task automatic send_oct(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      @(negedge clk);
      owc = 1'b1;
      owd = b[i];
      ows = (i == 7);
      @(negedge clk);
      owc = 1'b0;
    end
    qo.push_back(b);
  endtask
  // ready lags the push, so settle before looking at it again
  task automatic fill(input int n);
    n_acc = 0;
    while (orderwire_src_ready === 1'b1 && n_acc < n) begin
      send_oct(8'($random(seed)));
      n_acc++;
      repeat (3) @(negedge clk);
    end
  endtask
  task automatic wait_idx(input int n);
    int i;
    for (i = 0; i < 6000 && bidx != n; i++) begin
      @(negedge clk);
    end
    if (bidx != n) begin
      n_mismatch++;
      test_done();
    end
  endtask
  // a fresh client octet whenever the adapter asks for one
  always @(negedge clk) begin
    if (user_src_clock === 1'b1) begin
      udat = 8'($random(seed));
    end
  end

  // ****************************************
  // reference models
  // ****************************************
  // repeat, normal read or read after a discarded octet
  task automatic ow_src_chk(input logic [7:0] got);
    checked++;
    if (got === last) begin
      n_rep++;
    end else if (qo.size() > 0 && got === qo[0]) begin
      last = qo.pop_front();
    end else if (qo.size() > 1 && got === qo[1]) begin
      n_skip++;
      void'(qo.pop_front());
      last = qo.pop_front();
    end else begin
      cmp8(got, last);
    end
  endtask
  // octets straddling a trail or select change are not judged
  task automatic ow_sink_bit();
    logic [7:0] e;
    if (gap > 0) cmp1(gap == RSOCA_OW_DIV_INT);
    gap = 1;
    if (orderwire_octet_start === 1'b1) begin
      cmp1(nb == 8 || nst == 0);
      nb = 0;
      nst++;
      cfg_p = cfg_s;
      cfg_s = {tf, snk_sel};
      a_cur = st_cur;
      a_prev = st_prev;
    end
    asm = {asm[6:0], orderwire_data};
    nb++;
    if (nb == 8 && nst > 1 && cfg_p == cfg_s && cfg_s == {tf, snk_sel}) begin
      e = tf ? RSOCA_ALL_ONES : ((asm === a_prev) ? a_prev : a_cur);
      cmp8(asm, e);
    end
  endtask
  // outputs seen here were launched by the strobe of the previous edge
  always @(posedge clk) begin
    if (run) begin
      cmp1(comm_channel_server_fail === tf_q);
      cmp1(user_channel_server_fail === tf_q);
      cmp1(orderwire_server_fail === tf_q);
      if (comm_channel_clock === 1'b1) cmp8(comm_channel_data, qc.pop_front());
      if (user_channel_clock === 1'b1) cmp8(user_channel_data, qu.pop_front());
      if (user_src_clock === 1'b1) cmp1(lslot == 0);
      if (section_overhead_insert === 1'b1) begin
        if (lslot == slot(src_sel)) begin
          ow_src_chk(section_overhead_data_out);
        end else begin
          cmp1(lslot == RSOCA_IDX_F1);
          cmp8(section_overhead_data_out, udat);
        end
      end else begin
        cmp8(section_overhead_data_out, RSOCA_BYTE_RST);
      end
      if (orderwire_clock === 1'b1) begin
        ow_sink_bit();
      end else if (gap > 0) begin
        gap++;
      end
      tf_q = tf;
      lslot = -1;
      if (strobe) begin
        bidx = fs ? 0 : bidx + 1;
        lslot = bidx;
        if (bidx == RSOCA_IDX_D1 || bidx == RSOCA_IDX_D2 || bidx == RSOCA_IDX_D3) begin
          qc.push_back(sdata);
        end
        if (bidx == RSOCA_IDX_F1) qu.push_back(tf ? RSOCA_ALL_ONES : sdata);
        if (bidx == slot(snk_sel)) begin
          st_prev = st_cur;
          st_cur = sdata;
        end
      end
    end
  end

  // ****************************************
  // sequence
  // ****************************************
  initial begin
    repeat (99000) @(posedge clk);
    n_mismatch++;
    test_done();
  end
  initial begin
    {rst_n, tf, tf_q, run, slow, owd, owc, ows} = 8'h00;
    {udat, last, asm, st_cur, st_prev, a_cur, a_prev} = 56'h0;
    {cfg_s, cfg_p} = 4'h0;
    src_sel = RSOCA_SEL_E1;
    snk_sel = RSOCA_SEL_E1;
    lslot = -1;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
    run = 1'b1;
    fill(20);
    cmp1(n_acc >= RSOCA_SLIP_DEPTH && n_acc < 20);
    repeat (25000) @(negedge clk);
    $display("test 1 fill and drain on E1 done");
    wait_idx(1000);
    tf = 1'b1;
    repeat (12000) @(negedge clk);
    wait_idx(1000);
    tf = 1'b0;
    repeat (6000) @(negedge clk);
    $display("test 2 trail fail done");
    wait_idx(1000);
    src_sel = RSOCA_SEL_F1;
    snk_sel = RSOCA_SEL_F1;
    slow = 1'b1;
    fill(3);
    repeat (25000) @(negedge clk);
    $display("test 3 F1 with slow bytes done");
    cmp1(n_rep > 0);
    cmp1(n_skip > 0);
    test_done();
  end
endmodule
